// >>> common/sfcf_pkg.sv
// Shared constants and types of the serial flash command front end
package sfcf_pkg;

  // --------------------------------------------------------------------------
  // Frame layout
  // --------------------------------------------------------------------------
  localparam int OPCODE_BITS = 8;
  localparam int ADDR_BITS = 24;
  localparam int ADDR_BYTES = 3;
  localparam int PAGE_BITS = 10;
  localparam int BYTE_BITS = 9;
  localparam int BIN_BYTE_BITS = 8;
  localparam int PAGES = 1024;
  localparam int PAGE_STD = 264;
  localparam int PAGE_BIN = 256;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [1:0] LAST_ADDR_BYTE = 2'h2;

  // --------------------------------------------------------------------------
  // Pin synchroniser order and values after reset
  // --------------------------------------------------------------------------
  localparam int PIN_COUNT = 5;
  localparam int PIN_SEL = 0;
  localparam int PIN_SCK = 1;
  localparam int PIN_SI = 2;
  localparam int PIN_LOCK = 3;
  localparam int PIN_RST = 4;
  localparam logic [4:0] SYNC_RESET_VAL = 5'h19;

  // --------------------------------------------------------------------------
  // Frame states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0]
  {
    ST_STANDBY = 3'b000,
    ST_OPCODE = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b011,
    ST_DISCARD = 3'b100
  } sfcf_state_type;

endpackage : sfcf_pkg

// >>> verilog/sfcf_frontend.sv
// Serial command front end: framing, shifting, address decode, protection, buffer
// Summary of operation
// - A select falling edge starts an operation; its rising edge ends it.
// - Deselected: standby, output released, serial input ignored.
// - After a program or erase frame, stay active until the internal cycle ends.
// - Serial input is sampled on each rising shift clock edge.
// - Output bits change on the falling shift clock edge.
// - Opcode, address and data travel most significant bit first.
// - Locations are three address bytes with leading don't-care padding.
// - 264-byte pages: nine buffer bits, ten page bits, nine byte bits.
// - 256-byte pages: eight buffer bits, linear address of ten page, eight byte bits.
// - With lock low, marked sectors are shielded regardless of software enable.
// - With lock low, protection register changes are refused.
// - Program or erase under lock low is discarded; idle at select release.
// - Enable-protection and lockdown commands still run under lock low.
// - An open lock input reads as deasserted.
// - Reset pin low aborts, holds idle, and resumes when high.
// - The internal power-on reset initialises the device.
// - Page size 264 or 256 bytes, 264 by default, picks the layout.
// - The array has 1,024 pages, ten page bits.
// - Works in SPI mode 0 and mode 3.
// - One data buffer of 264 bytes, wrapping at the configured page size.
module sfcf_frontend
#(
  parameter logic [7:0] OPC_BUF_WRITE = 8'h10,
  parameter logic [7:0] OPC_BUF_READ = 8'h11,
  parameter logic [7:0] OPC_PGM_LO = 8'h20,
  parameter logic [7:0] OPC_PGM_HI = 8'h2F,
  parameter logic [7:0] OPC_PROT_REG_WR = 8'h30,
  parameter logic [7:0] OPC_PROT_ENABLE = 8'h31,
  parameter logic [7:0] OPC_LOCKDOWN = 8'h32,
  parameter int SECTORS = 8,
  parameter int SECTOR_SHIFT = 7
)
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic DEVICE_SELECT_N,
  input wire logic SHIFT_CLOCK,
  input wire logic SERIAL_INPUT,
  output logic SERIAL_OUTPUT,
  output logic SERIAL_OUTPUT_OE,
  input wire logic PROTECT_LOCK_N,
  input wire logic RESET_PIN_N,
  input wire logic PAGE_SIZE_256,
  input wire logic SW_PROT_EN,
  input wire logic [SECTORS-1:0] PROT_MAP,
  input wire logic ARRAY_BUSY,
  input wire logic [7:0] RD_BYTE,
  output logic RD_LOAD,
  output logic CMD_VALID,
  output logic [sfcf_pkg::OPCODE_BITS-1:0] CMD_OPCODE,
  output logic [sfcf_pkg::PAGE_BITS-1:0] CMD_PAGE,
  output logic [sfcf_pkg::BYTE_BITS-1:0] CMD_BYTE,
  output logic [sfcf_pkg::BYTE_BITS-1:0] CMD_BUF_ADDR,
  output logic CMD_PROTECTED,
  output logic WR_STROBE,
  output logic [7:0] WR_BYTE,
  output logic FRAME_END,
  output logic CMD_DISCARDED,
  output logic STANDBY
);
  import sfcf_pkg::*;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [PIN_COUNT-1:0] pins;
  logic [PIN_COUNT-1:0] meta_q;
  logic [PIN_COUNT-1:0] sync_q;

  assign pins = {RESET_PIN_N, PROTECT_LOCK_N, SERIAL_INPUT, SHIFT_CLOCK, DEVICE_SELECT_N};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++)
    begin : g_sync
      always_ff @(posedge CLK)
      begin
        if (!RSTN)
        begin
          meta_q[gi] <= SYNC_RESET_VAL[gi];
          sync_q[gi] <= SYNC_RESET_VAL[gi];
        end
        else
        begin
          meta_q[gi] <= pins[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  logic sel_n;
  logic sck;
  logic si;
  logic lock_n;
  logic hold;
  logic sck_prev_q;
  logic sel_prev_q;

  assign sel_n = sync_q[PIN_SEL];
  assign sck = sync_q[PIN_SCK];
  assign si = sync_q[PIN_SI];
  assign lock_n = sync_q[PIN_LOCK];
  assign hold = !sync_q[PIN_RST];

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      sck_prev_q <= 1'b0;
      sel_prev_q <= 1'b1;
    end
    else
    begin
      sck_prev_q <= sck;
      sel_prev_q <= sel_n;
    end
  end

  // --------------------------------------------------------------------------
  // Edge events; shift clock edges seen only while selected and not held by the reset pin
  // --------------------------------------------------------------------------
  logic sel_fall;
  logic sel_rise;
  logic sck_rise;
  logic sck_fall;

  assign sel_fall = !sel_n && sel_prev_q;
  assign sel_rise = sel_n && !sel_prev_q;
  assign sck_rise = sck && !sck_prev_q && !sel_n && !hold;
  assign sck_fall = !sck && sck_prev_q && !sel_n && !hold;

  // --------------------------------------------------------------------------
  // Frame state and bit counting
  // --------------------------------------------------------------------------
  sfcf_state_type state_q;
  logic [2:0] bit_q;
  logic [1:0] byte_q;
  logic [7:0] in_q;
  logic [ADDR_BITS-1:0] addr_q;
  logic [7:0] in_next;
  logic [ADDR_BITS-1:0] addr_next;
  logic byte_done;
  logic opc_done;
  logic addr_done;
  logic is_pgm;
  logic is_prot_wr;
  logic is_exempt;
  logic refuse;

  assign in_next = {in_q[6:0], si};
  assign addr_next = {addr_q[ADDR_BITS-2:0], si};
  assign byte_done = sck_rise && (bit_q == LAST_BIT);
  assign opc_done = byte_done && (state_q == ST_OPCODE);
  assign addr_done = byte_done && (state_q == ST_ADDR) && (byte_q == LAST_ADDR_BYTE);

  assign is_pgm = (in_next >= OPC_PGM_LO) && (in_next <= OPC_PGM_HI);
  assign is_prot_wr = (in_next == OPC_PROT_REG_WR);
  assign is_exempt = (in_next == OPC_PROT_ENABLE) || (in_next == OPC_LOCKDOWN);
  assign refuse = !lock_n && (is_pgm || is_prot_wr) && !is_exempt;

  always_ff @(posedge CLK)
  begin
    if (!RSTN || hold)
    begin
      state_q <= ST_STANDBY;
    end
    else if (sel_rise)
    begin
      state_q <= ST_STANDBY;
    end
    else
    begin
      case (state_q)
        ST_STANDBY:
        begin
          if (sel_fall)
          begin
            state_q <= ST_OPCODE;
          end
        end
        ST_OPCODE:
        begin
          if (opc_done)
          begin
            state_q <= refuse ? ST_DISCARD : ST_ADDR;
          end
        end
        ST_ADDR:
        begin
          if (addr_done)
          begin
            state_q <= ST_DATA;
          end
        end
        ST_DATA:
        begin
          state_q <= ST_DATA;
        end
        ST_DISCARD:
        begin
          state_q <= ST_DISCARD;
        end
        default:
        begin
          state_q <= ST_STANDBY;
        end
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN || hold || sel_rise || (state_q == ST_STANDBY))
    begin
      bit_q <= 3'h0;
      byte_q <= 2'h0;
      in_q <= 8'h00;
    end
    else if (sck_rise)
    begin
      bit_q <= bit_q + 3'h1;
      in_q <= in_next;
      if (byte_done && (state_q == ST_ADDR))
      begin
        byte_q <= byte_q + 2'h1;
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      addr_q <= 24'h00_0000;
    end
    else if (sck_rise && (state_q == ST_ADDR))
    begin
      addr_q <= addr_next;
    end
  end

  // --------------------------------------------------------------------------
  // Command capture and address decode
  // --------------------------------------------------------------------------
  logic [PAGE_BITS-1:0] page_dec;
  logic [BYTE_BITS-1:0] byte_dec;
  logic [8:0] page_len;
  logic [$clog2(SECTORS)-1:0] sector;

  always_comb
  begin
    if (PAGE_SIZE_256)
    begin
      page_dec = addr_next[BIN_BYTE_BITS +: PAGE_BITS];
      byte_dec = {1'b0, addr_next[BIN_BYTE_BITS-1:0]};
      page_len = 9'(PAGE_BIN);
    end
    else
    begin
      page_dec = addr_next[BYTE_BITS +: PAGE_BITS];
      byte_dec = addr_next[BYTE_BITS-1:0];
      page_len = 9'(PAGE_STD);
    end
  end

  assign sector = page_dec[SECTOR_SHIFT +: $clog2(SECTORS)];

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      CMD_OPCODE <= 8'h00;
      CMD_PAGE <= 10'h000;
      CMD_BYTE <= 9'h000;
      CMD_BUF_ADDR <= 9'h000;
      CMD_PROTECTED <= 1'b0;
    end
    else if (opc_done)
    begin
      CMD_OPCODE <= in_next;
    end
    else if (addr_done)
    begin
      CMD_PAGE <= page_dec;
      CMD_BYTE <= byte_dec;
      CMD_BUF_ADDR <= byte_dec;
      CMD_PROTECTED <= PROT_MAP[sector] && (SW_PROT_EN || !lock_n);
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN || hold)
    begin
      CMD_VALID <= 1'b0;
      CMD_DISCARDED <= 1'b0;
      FRAME_END <= 1'b0;
    end
    else
    begin
      CMD_VALID <= addr_done;
      CMD_DISCARDED <= opc_done && refuse;
      FRAME_END <= sel_rise && (state_q != ST_STANDBY);
    end
  end

  // --------------------------------------------------------------------------
  // Write data and read requests
  // --------------------------------------------------------------------------
  logic data_byte;

  assign data_byte = byte_done && (state_q == ST_DATA);

  always_ff @(posedge CLK)
  begin
    if (!RSTN || hold)
    begin
      WR_STROBE <= 1'b0;
      WR_BYTE <= 8'h00;
      RD_LOAD <= 1'b0;
    end
    else
    begin
      WR_STROBE <= data_byte;
      RD_LOAD <= addr_done || data_byte;
      if (data_byte)
      begin
        WR_BYTE <= in_next;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Page buffer
  // --------------------------------------------------------------------------
  logic [7:0] buf_mem [0:PAGE_STD-1];
  logic [8:0] ptr_q;
  logic [8:0] ptr_inc;
  logic [8:0] ptr_start;
  logic [8:0] rd_idx;
  logic [7:0] buf_rd_q;
  logic buf_wr_op;
  logic buf_rd_op;

  assign buf_wr_op = (CMD_OPCODE == OPC_BUF_WRITE);
  assign buf_rd_op = (CMD_OPCODE == OPC_BUF_READ);
  // The first read request falls in the cycle that loads the start address
  assign ptr_start = (CMD_BUF_ADDR >= page_len) ? 9'h000 : CMD_BUF_ADDR;
  assign rd_idx = CMD_VALID ? ptr_start : ptr_q;
  assign ptr_inc = (rd_idx == page_len - 9'h001) ? 9'h000 : rd_idx + 9'h001;

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      ptr_q <= 9'h000;
    end
    else if (CMD_VALID)
    begin
      ptr_q <= buf_rd_op ? ptr_inc : ptr_start;
    end
    else if ((WR_STROBE && buf_wr_op) || (RD_LOAD && buf_rd_op))
    begin
      ptr_q <= ptr_inc;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (WR_STROBE && buf_wr_op)
    begin
      buf_mem[ptr_q] <= WR_BYTE;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      buf_rd_q <= 8'h00;
    end
    else if (RD_LOAD)
    begin
      buf_rd_q <= buf_mem[rd_idx];
    end
  end

  // --------------------------------------------------------------------------
  // Serial output
  // --------------------------------------------------------------------------
  logic load_q;
  logic [7:0] out_q;

  always_ff @(posedge CLK)
  begin
    if (!RSTN || hold)
    begin
      load_q <= 1'b0;
      out_q <= 8'h00;
      SERIAL_OUTPUT <= 1'b0;
      SERIAL_OUTPUT_OE <= 1'b0;
    end
    else if (sel_n)
    begin
      load_q <= 1'b0;
      SERIAL_OUTPUT_OE <= 1'b0;
    end
    else
    begin
      load_q <= RD_LOAD;
      if (load_q)
      begin
        out_q <= buf_rd_op ? buf_rd_q : RD_BYTE;
      end
      else if (sck_fall && (state_q == ST_DATA))
      begin
        SERIAL_OUTPUT <= out_q[7];
        out_q <= {out_q[6:0], 1'b0};
        SERIAL_OUTPUT_OE <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Self-timed cycle tracking and standby
  // --------------------------------------------------------------------------
  logic active_q;
  logic guard_q;

  always_ff @(posedge CLK)
  begin
    if (!RSTN || hold)
    begin
      active_q <= 1'b0;
      guard_q <= 1'b0;
    end
    else if (sel_rise && (state_q == ST_DATA) && (CMD_OPCODE >= OPC_PGM_LO) && (CMD_OPCODE <= OPC_PGM_HI))
    begin
      active_q <= 1'b1;
      guard_q <= 1'b1;
    end
    else if (guard_q)
    begin
      guard_q <= 1'b0;
    end
    else if (!ARRAY_BUSY)
    begin
      active_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      STANDBY <= 1'b1;
    end
    else
    begin
      STANDBY <= sel_n && !active_q && (state_q == ST_STANDBY);
    end
  end

endmodule : sfcf_frontend

// >>> sim/sfcf_frontend_properties.sv
// Concurrent checks on the front end ports
module sfcf_frontend_properties
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic DEVICE_SELECT_N,
  input wire logic RESET_PIN_N,
  input wire logic PROTECT_LOCK_N,
  input wire logic ARRAY_BUSY,
  input wire logic SERIAL_OUTPUT_OE,
  input wire logic CMD_VALID,
  input wire logic WR_STROBE,
  input wire logic FRAME_END,
  input wire logic CMD_DISCARDED,
  input wire logic STANDBY
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence sel_idle_s;
    DEVICE_SELECT_N [*6];
  endsequence
  sequence busy_done_s;
    DEVICE_SELECT_N && $fell(ARRAY_BUSY) ##1 DEVICE_SELECT_N;
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sel_idle_a: assert property (sel_idle_s |-> !SERIAL_OUTPUT_OE)
    else $error("output driven while deselected");
  frame_end_a: assert property (FRAME_END |-> DEVICE_SELECT_N ##1 !FRAME_END [*8])
    else $error("frame end without select release");
  cmd_valid_a: assert property (CMD_VALID |-> !DEVICE_SELECT_N ##1 !CMD_VALID [*8])
    else $error("command valid outside a frame");
  wr_gap_a: assert property (WR_STROBE |=> !WR_STROBE [*8])
    else $error("write strobes too close");
  discard_quiet_a: assert property (CMD_DISCARDED |-> !PROTECT_LOCK_N ##1 (!CMD_VALID && !WR_STROBE) [*8])
    else $error("discarded command went on");
  busy_hold_a: assert property ((!STANDBY && ARRAY_BUSY && DEVICE_SELECT_N && RESET_PIN_N) |=> !STANDBY)
    else $error("standby during self-timed cycle");
  busy_wake_a: assert property (busy_done_s |-> ##[0:2] STANDBY)
    else $error("no standby after cycle end");
  power_on_a: assert property ($rose(RSTN) |-> STANDBY && !SERIAL_OUTPUT_OE && !CMD_VALID)
    else $error("bad state after reset");
  pin_reset_a: assert property ((!RESET_PIN_N) [*6] |-> !SERIAL_OUTPUT_OE && !CMD_VALID && !WR_STROBE)
    else $error("activity while reset pin low");
endmodule : sfcf_frontend_properties

// >>> sim/sfcf_host_model.sv
// Host master model driving select, shift clock and serial input
module sfcf_host_model
(
  output logic sel_n,
  output logic sck,
  output logic si,
  input wire logic so
);
  timeunit 1ns;
  timeprecision 1ns;
  logic m3;
  initial
  begin
    sel_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    m3 = 1'b0;
  end
  // ----------------------------------------
  // Frame tasks
  // ----------------------------------------
  task automatic start(input logic mode3);
    m3 = mode3;
    sck = mode3;
    #37 sel_n = 1'b0;
    #100;
  endtask : start
  task automatic bits(input logic [31:0] v, input int n, output logic [31:0] rx);
    rx = '0;
    for (int i = n - 1; i >= 0; i--)
    begin
      sck = 1'b0;
      si = v[i];
      #90 sck = 1'b1;
      rx = {rx[30:0], so};
      #70;
    end
    sck = m3;
  endtask : bits
  task automatic stop;
    #100 sel_n = 1'b1;
    si = ~si;
    #400;
  endtask : stop
endmodule : sfcf_host_model

// >>> sim/sfcf_frontend_tb_top.sv
// Self-checking bench of the serial command front end
module sfcf_frontend_tb_top;
  import sfcf_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] OPC_RD = 8'h03;
  localparam logic [7:0] RD_VAL = 8'hA5;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic lock_n = 1'b1;
  logic rpin_n = 1'b1;
  logic ps256 = 1'b0;
  logic swp = 1'b0;
  logic [7:0] pmap = 8'h84;
  logic sel_n, sck, si, so, oe, so_w, busy, rd_load, cvalid, cprot, wstb, fend, disc, stby;
  logic so_last = 1'b0;
  logic arm = 1'b0;
  logic [7:0] copc, wbyte, k_wr;
  logic [9:0] cpage;
  logic [8:0] cbyte, cbuf;
  logic [36:0] k_cmd;
  int bcnt = 0;
  int nv = 0;
  int nw = 0;
  int nd = 0;
  int nr = 0;
  int fails = 0;
  int cmp_count = 0;
  initial forever #10 clk = ~clk;
  always @(posedge clk) if (oe === 1'b1) so_last <= so;
  assign so_w = (oe === 1'b1) ? so : ~so_last;
  // The array answers in the same cycle as the frame end pulse
  assign busy = (bcnt > 0) || (arm && (fend === 1'b1));
  // ----------------------------------------
  // Array side and monitors
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (fend === 1'b1 && arm)
      bcnt <= 40;
    else if (bcnt > 0)
      bcnt <= bcnt - 1;
    if (cvalid === 1'b1)
      k_cmd <= {copc, cpage, cbyte, cbuf, cprot};
    if (wstb === 1'b1)
      k_wr <= wbyte;
    nv <= nv + int'(cvalid === 1'b1);
    nw <= nw + int'(wstb === 1'b1);
    nd <= nd + int'(disc === 1'b1);
    nr <= nr + int'(rd_load === 1'b1);
  end
  sfcf_host_model i_host (.sel_n(sel_n), .sck(sck), .si(si), .so(so_w));
  sfcf_frontend i_dut
  (
    .CLK(clk),
    .RSTN(rstn),
    .DEVICE_SELECT_N(sel_n),
    .SHIFT_CLOCK(sck),
    .SERIAL_INPUT(si),
    .SERIAL_OUTPUT(so),
    .SERIAL_OUTPUT_OE(oe),
    .PROTECT_LOCK_N(lock_n),
    .RESET_PIN_N(rpin_n),
    .PAGE_SIZE_256(ps256),
    .SW_PROT_EN(swp),
    .PROT_MAP(pmap),
    .ARRAY_BUSY(busy),
    .RD_BYTE(RD_VAL),
    .RD_LOAD(rd_load),
    .CMD_VALID(cvalid),
    .CMD_OPCODE(copc),
    .CMD_PAGE(cpage),
    .CMD_BYTE(cbyte),
    .CMD_BUF_ADDR(cbuf),
    .CMD_PROTECTED(cprot),
    .WR_STROBE(wstb),
    .WR_BYTE(wbyte),
    .FRAME_END(fend),
    .CMD_DISCARDED(disc),
    .STANDBY(stby)
  );
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic cmp(input string nm, input logic [39:0] e, input logic [39:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task automatic frm(input logic [7:0] op, input logic m3);
    logic [31:0] rx;
    i_host.start(m3);
    i_host.bits({op, 24'h00_0000}, 32, rx);
    i_host.bits(32'h0000_005A, 8, rx);
    i_host.stop();
  endtask : frm
  task automatic t_cmd(input logic [23:0] a, input logic p, input logic m3, input logic pr);
    logic [31:0] rx;
    logic [36:0] e;
    @(negedge clk) ps256 = p;
    k_cmd = 'x;
    e = p ? {OPC_RD, a[17:8], 1'b0, a[7:0], 1'b0, a[7:0], pr} : {OPC_RD, a[18:9], a[8:0], a[8:0], pr};
    i_host.start(m3);
    i_host.bits({OPC_RD, a}, 32, rx);
    i_host.bits(32'h0000_0000, 8, rx);
    i_host.stop();
    cmp("command fields", {3'b000, e}, {3'b000, k_cmd});
    cmp("read byte", RD_VAL, rx[7:0]);
  endtask : t_cmd
  task automatic t_wr;
    logic [31:0] rx;
    int n;
    int r;
    n = nw;
    r = nr;
    i_host.start(1'b0);
    i_host.bits({i_dut.OPC_BUF_WRITE, 24'h00_0000}, 32, rx);
    i_host.bits(32'h0000_3CC3, 16, rx);
    i_host.bits(32'h0000_000F, 4, rx);
    i_host.stop();
    cmp("write strobes", n + 2, nw);
    cmp("write byte", 8'hC3, k_wr);
    cmp("read requests", r + 3, nr);
    i_host.start(1'b0);
    i_host.bits({i_dut.OPC_BUF_READ, 24'h00_0000}, 32, rx);
    i_host.bits(32'h0000_0000, 16, rx);
    i_host.stop();
    cmp("buffer read", 16'h3CC3, rx[15:0]);
  endtask : t_wr
  task automatic t_prog;
    arm = 1'b1;
    frm(i_dut.OPC_PGM_LO, 1'b0);
    arm = 1'b0;
    cmp("standby in cycle", 1'b0, stby);
    repeat (30) @(negedge clk);
    cmp("standby after cycle", 1'b1, stby);
  endtask : t_prog
  task automatic t_lock;
    int n;
    int d;
    n = nv;
    d = nd;
    @(negedge clk) lock_n = 1'b0;
    frm(i_dut.OPC_PGM_HI, 1'b0);
    frm(i_dut.OPC_PROT_REG_WR, 1'b1);
    cmp("discards", d + 2, nd);
    cmp("standby", 1'b1, stby);
    frm(i_dut.OPC_LOCKDOWN, 1'b0);
    frm(i_dut.OPC_PROT_ENABLE, 1'b1);
    cmp("lock commands", n + 2, nv);
    t_cmd(24'h07_0000, 1'b0, 1'b0, 1'b1);
    @(negedge clk) lock_n = 1'b1;
  endtask : t_lock
  task automatic t_rpin;
    logic [31:0] rx;
    int n;
    n = nv;
    i_host.start(1'b0);
    i_host.bits({OPC_RD, 8'h00}, 16, rx);
    @(negedge clk) rpin_n = 1'b0;
    repeat (8) @(negedge clk);
    cmp("output in reset", 1'b0, oe);
    rpin_n = 1'b1;
    i_host.bits(32'h0000_0000, 24, rx);
    i_host.stop();
    cmp("aborted frame", n, nv);
  endtask : t_rpin
  task automatic t_desel;
    logic [31:0] rx;
    int n;
    n = nv;
    i_host.bits(32'hA5A5_0000, 32, rx);
    repeat (8) @(negedge clk);
    cmp("deselected", n, nv);
    cmp("deselected output", 1'b0, oe);
  endtask : t_desel
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    cmp("standby after reset", 1'b1, stby);
    t_cmd(24'h01_0203, 1'b0, 1'b0, 1'b0);
    t_cmd(24'h03_FF7E, 1'b1, 1'b1, 1'b0);
    @(negedge clk) swp = 1'b1;
    t_cmd(24'h03_FF7E, 1'b1, 1'b0, 1'b1);
    @(negedge clk) swp = 1'b0;
    t_wr();
    t_prog();
    t_lock();
    t_rpin();
    t_cmd(24'h07_FE01, 1'b0, 1'b1, 1'b0);
    t_desel();
    give_verdict();
  end
  initial
  begin
    #1_000_000;
    fails++;
    give_verdict();
  end
endmodule : sfcf_frontend_tb_top
bind sfcf_frontend sfcf_frontend_properties i_props
(
  .CLK(CLK),
  .RSTN(RSTN),
  .DEVICE_SELECT_N(DEVICE_SELECT_N),
  .RESET_PIN_N(RESET_PIN_N),
  .PROTECT_LOCK_N(PROTECT_LOCK_N),
  .ARRAY_BUSY(ARRAY_BUSY),
  .SERIAL_OUTPUT_OE(SERIAL_OUTPUT_OE),
  .CMD_VALID(CMD_VALID),
  .WR_STROBE(WR_STROBE),
  .FRAME_END(FRAME_END),
  .CMD_DISCARDED(CMD_DISCARDED),
  .STANDBY(STANDBY)
);
